// ---- shared/msw_map.svh ----
// msw_map.svh: offsets, fields, reset values and timing counts of the
// memory select switch block; included by the package, msw_debounce and msw_top
`ifndef MSW_MAP_SVH
`define MSW_MAP_SVH

// register byte offsets on the avalon slave
`define MSW_REG_CONFIG 4'h0
`define MSW_REG_DEBOUNCE 4'h4
`define MSW_REG_STATUS 4'h8

// config field positions
`define MSW_CFG_MODE_LO 0
`define MSW_CFG_MODE_HI 1
`define MSW_CFG_PULL_UP 2
`define MSW_CFG_VALID_LO 3
`define MSW_CFG_VALID_HI 6
`define MSW_CFG_ROCK_LO 7
`define MSW_CFG_ROCK_HI 8
`define MSW_CFG_SHORT_VOL 9
`define MSW_CFG_THR_LO 10
`define MSW_CFG_THR_HI 12
`define MSW_CFG_IND_EN 13

// reset values
`define MSW_CONFIG_RST 32'h0000_2678
`define MSW_DEBOUNCE_RST 16'h0032

// memory codes
`define MSW_MEM_A 2'h0
`define MSW_MEM_B 2'h1
`define MSW_MEM_C 2'h2
`define MSW_MEM_D 2'h3

// timing: clock period, one millisecond tick, seconds to ms
`define MSW_CLK_NS 20
`define MSW_MS_NS 1000000
`define MSW_MS_CYCLES (`MSW_MS_NS / `MSW_CLK_NS)
`define MSW_MS_PER_S 13'd1000
`define MSW_THR_MIN_S 3'h1
`define MSW_THR_MAX_S 3'h5
`define MSW_SETTLE_CYCLES 3'h4

`endif

// ---- shared/msw_pkg.sv ----
// msw_pkg: types shared by the memory select switch block
// assumes msw_map.svh sits on the include path
package msw_pkg;
  `include "msw_map.svh"

  typedef logic [1:0] msw_mem_t;

  // select switch wiring modes
  typedef enum logic [1:0] {
    MSW_MOMENTARY = 2'h0,
    MSW_MOM_DONLY = 2'h1,
    MSW_STAT_DONLY = 2'h2,
    MSW_STAT_PLAIN = 2'h3
  } msw_ms_mode_e;

  // rocker modes
  typedef enum logic [1:0] {
    MSW_RK_OFF = 2'h0,
    MSW_RK_VOLUME = 2'h1,
    MSW_RK_MEMORY = 2'h2,
    MSW_RK_MIXED = 2'h3
  } msw_rk_mode_e;

  // select path states
  typedef enum logic [1:0] {
    MSW_SEL_NORMAL = 2'b01,
    MSW_SEL_OVERRIDE = 2'b10
  } msw_sel_state_e;

  // rocker closure states
  typedef enum logic [2:0] {
    MSW_RK_IDLE = 3'b001,
    MSW_RK_HELD = 3'b010,
    MSW_RK_DONE = 3'b100
  } msw_rk_state_e;

  // switch levels, lsb first: select one, select two, volume up, volume down
  typedef struct packed {
    logic volume_down_input;
    logic volume_up_input;
    logic select_input_two;
    logic select_input_one;
  } msw_sw_s;

  // one-cycle step requests from the rocker
  typedef struct packed {
    logic vol_up;
    logic vol_dn;
    logic mem_up;
    logic mem_dn;
  } msw_step_s;

  // rocker settings
  typedef struct packed {
    msw_rk_mode_e mode;
    logic short_is_vol;
    logic [12:0] thr_ms;
  } msw_rk_cfg_s;
endpackage

// ---- sim/msw_switch_model.sv ----
// msw_switch_model: mechanical select and rocker switches in front of the pins
// assumes wanted levels change just after a rising edge of sys_clk_i
module msw_switch_model (
  // clock
  input wire logic sys_clk_i,
  // wanted levels from the bench
  input wire msw_pkg::msw_sw_s target_i,
  // contact levels, bouncing after each change
  output msw_pkg::msw_sw_s pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import msw_pkg::*;
  msw_sw_s settled_q = '0;
  msw_sw_s chg_q = '0;
  int cnt = 0;
  initial pins_o = '0;
  // a change chatters for six cycles, shorter than any debounce period
  always @(posedge sys_clk_i) begin
    if (target_i !== settled_q) begin
      settled_q <= target_i;
      chg_q <= target_i ^ settled_q;
      cnt <= 6;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      pins_o <= pins_o ^ chg_q;
    end else begin
      pins_o <= settled_q;
    end
  end
endmodule // msw_switch_model

// ---- sim/msw_top_test.sv ----
// msw_top_test: self-checking bench for the memory select switch block
// assumes a 10-cycle ms tick; results are queued and matched by watchers
module msw_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import msw_pkg::*;
  logic sys_clk_i = 0;
  logic rst_n_i = 0;
  logic [3:0] adr = 4'h0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wt;
  logic [3:0] tgt = 4'h0;
  msw_sw_s pins;
  msw_mem_t mem;
  logic fade, ind, gup, gdn;
  int num_errors = 0;
  int comparisons = 0;
  logic ind_on = 1;
  int seed = 30650;
  int m, n;
  msw_mem_t cur = 2'h0;
  msw_mem_t mq[$];
  logic [1:0] gq[$];
  logic [31:0] cfgs[3] = '{32'h247b, 32'h247a, 32'h247e};
  int st0[3] = '{3, 3, 1};
  int seq[3][4] = '{'{1, 0, 2, 3}, '{1, 0, 3, 3}, '{3, 3, 0, 1}};

  // 50 mhz clock
  initial forever #10 sys_clk_i = ~sys_clk_i;

  msw_top #(.TICK_CYCLES(10)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .select_input_one_i(pins.select_input_one), .select_input_two_i(pins.select_input_two),
    .volume_up_input_i(pins.volume_up_input), .volume_down_input_i(pins.volume_down_input),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .memory_choice_o(mem),
    .fade_req_o(fade), .indicator_req_o(ind), .gain_up_o(gup), .gain_down_o(gdn));

  msw_switch_model sw_u (.sys_clk_i(sys_clk_i), .target_i(tgt), .pins_o(pins));

  task close_out;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task cmp_word(string what, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, e, g);
    end
  endtask

  task cmp_out(string what, logic [1:0] e, logic [1:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, e, g);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge sys_clk_i);
    end while (wt !== 1'b0);
    q = rdat;
    rd <= 0;
    wr <= 0;
  endtask

  task wreg(logic [3:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1, a, d, q);
  endtask

  task rchk(logic [3:0] a, logic [31:0] e, string what);
    logic [31:0] q;
    bus(0, a, 32'h0, q);
    cmp_word(what, e, q);
  endtask

  // note a memory change, only when the memory really moves
  task exp(int e);
    if (e >= 0 && e[1:0] !== cur) begin
      mq.push_back(e[1:0]);
      cur = e[1:0];
    end
  endtask

  // wait for queued results, then watch for strays
  task settle;
    int k;
    k = 0;
    while ((mq.size() != 0 || gq.size() != 0) && k < 400) begin
      @(posedge sys_clk_i);
      k++;
    end
    if (k >= 400) cmp_word("pending results", 0, mq.size() + gq.size());
    repeat (40) @(posedge sys_clk_i);
  endtask

  task flip(int i);
    @(posedge sys_clk_i);
    tgt[i] <= ~tgt[i];
    settle;
  endtask

  task press(int i, int hold);
    @(posedge sys_clk_i);
    tgt[i] <= ~tgt[i];
    repeat (hold) @(posedge sys_clk_i);
    tgt[i] <= ~tgt[i];
    settle;
  endtask

  // rocker closure; results are expected only after release
  task rock(int i, logic [1:0] g, int e);
    @(posedge sys_clk_i);
    tgt[i] <= 1'b1;
    repeat (60) @(posedge sys_clk_i);
    tgt[i] <= 1'b0;
    if (g != 2'b00) gq.push_back(g);
    exp(e);
    settle;
  endtask

  // long closure: the action must come while the switch is still held
  task longp(int i, logic [1:0] g, int e);
    @(posedge sys_clk_i);
    tgt[i] <= 1'b1;
    if (g != 2'b00) gq.push_back(g);
    exp(e);
    repeat (9000) @(posedge sys_clk_i);
    cmp_word("early long action", 1, mq.size() + gq.size());
    repeat (1600) @(posedge sys_clk_i);
    cmp_word("long action while held", 0, mq.size() + gq.size());
    tgt[i] <= 1'b0;
    settle;
  endtask

  // memory change watcher
  always @(posedge sys_clk_i) begin
    if (fade !== 1'b0) begin
      if (mq.size() == 0) cmp_out("unexpected memory", ~mem, mem);
      else cmp_out("memory", mq.pop_front(), mem);
      cmp_out("indicator", {1'b0, ind_on}, {1'b0, ind});
    end
  end

  // gain step watcher
  always @(posedge sys_clk_i) begin
    if ({gup, gdn} !== 2'b00) begin
      if (gq.size() == 0) cmp_out("unexpected gain", 2'b00, {gup, gdn});
      else cmp_out("gain", gq.pop_front(), {gup, gdn});
    end
  end

  // watchdog
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    cmp_word("watchdog", 0, 1);
    close_out;
  end

  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1;
    repeat (8) @(posedge sys_clk_i);
    rchk(4'h0, 32'h2678, "config reset");
    rchk(4'h4, 32'h32, "debounce reset");
    rchk(4'h8, 32'h100, "status");
    rchk(4'hc, 32'h0, "unmapped");
    wreg(4'h4, 32'h2);
    rchk(4'h4, 32'h2, "debounce");
    wreg(4'h0, 32'h2479);
    exp(1); press(0, 60);
    exp(2); press(0, 60);
    exp(3); flip(1);
    rchk(4'h8, 32'h127, "status override");
    press(0, 60);
    exp(2); flip(1);
    exp(0); press(0, 60);
    wreg(4'h0, 32'h2459);
    n = 1 + ($random(seed) & 3);
    for (int k = 0; k < n; k++) begin
      exp(cur == 2'h0 ? 1 : 0); press(0, 40 + ($random(seed) & 63));
    end
    m = cur;
    exp(3); flip(1);
    flip(0);
    exp(m); wreg(4'h0, 32'h247d);
    settle;
    exp(3); flip(1);
    exp(m); flip(1);
    exp(cur == 2'h2 ? 0 : cur + 1); press(0, 60);
    for (int c = 0; c < 3; c++) begin
      exp(st0[c]); wreg(4'h0, cfgs[c]);
      settle;
      for (int k = 0; k < 4; k++) begin
        exp(seq[c][k]); flip(1 - k % 2);
      end
    end
    exp(0); wreg(4'h0, 32'h200b);
    settle;
    wreg(4'h0, 32'h24f8);
    rock(2, 2'b10, -1);
    rock(3, 2'b01, -1);
    wreg(4'h0, 32'h2478);
    rock(2, 2'b00, -1);
    ind_on = 0;
    wreg(4'h0, 32'h0558);
    rock(2, 2'b00, 1);
    rock(2, 2'b00, 3);
    rock(2, 2'b00, 3);
    rock(3, 2'b00, 1);
    exp(3); press(0, 60);
    exp(0); press(0, 60);
    ind_on = 1;
    wreg(4'h0, 32'h27f8);
    rock(2, 2'b10, -1);
    longp(2, 2'b00, 1);
    wreg(4'h0, 32'h25f8);
    rock(2, 2'b00, 2);
    longp(3, 2'b01, -1);
    cmp_out("memory level", cur, mem);
    close_out;
  end
endmodule // msw_top_test

// ---- verilog/msw_debounce.sv ----
// msw_debounce: two-flop synchroniser and debouncer for the four switches
// assumes a one-cycle millisecond tick and a period in milliseconds
`include "msw_map.svh"

module msw_debounce (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // raw switches and timing
  input wire msw_pkg::msw_sw_s sw_raw_i,
  input wire logic tick_i,
  input wire logic [15:0] period_i,
  // debounced levels
  output msw_pkg::msw_sw_s sw_o,
  output logic ready_o
);
  import msw_pkg::*;

  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] stable_q;
  logic [3:0] stable_d;
  logic [2:0] settle_q;
  logic [2:0] settle_d;
  logic ready;

  // synchroniser flops and settle counter
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      settle_q <= 3'h0;
    end else begin
      meta_q <= sw_raw_i;
      sync_q <= meta_q;
      settle_q <= settle_d;
    end
  end

  // outputs copy the synchroniser, ready low, until it has filled
  always_comb begin
    settle_d = settle_q;
    if (settle_q != `MSW_SETTLE_CYCLES) begin
      settle_d = settle_q + 3'h1;
    end
  end
  assign ready = (settle_q == `MSW_SETTLE_CYCLES);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bit
      logic [15:0] cnt_q;
      logic [15:0] cnt_d;
      // [R22] debounce each input
      always_comb begin
        cnt_d = 16'h0;
        stable_d[g] = stable_q[g];
        if (!ready) begin
          stable_d[g] = sync_q[g];
        end else if (sync_q[g] != stable_q[g] && tick_i) begin
          if (cnt_q + 16'h1 >= period_i) begin
            stable_d[g] = sync_q[g];
          end else begin
            cnt_d = cnt_q + 16'h1;
          end
        end else if (sync_q[g] != stable_q[g]) begin
          cnt_d = cnt_q;
        end
      end
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cnt_q <= 16'h0;
          stable_q[g] <= 1'b0;
        end else begin
          cnt_q <= cnt_d;
          stable_q[g] <= stable_d[g];
        end
      end
    end
  endgenerate

  assign sw_o = stable_q;
  assign ready_o = ready;
endmodule // msw_debounce

// ---- verilog/msw_rocker.sv ----
// msw_rocker: classifies rocker closures into volume and memory steps
// assumes debounced closure levels, high while closed
module msw_rocker (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // switch levels and timing
  input wire logic up_i,
  input wire logic dn_i,
  input wire logic tick_i,
  input wire logic ready_i,
  input wire msw_pkg::msw_rk_cfg_s cfg_i,
  // step requests
  output msw_pkg::msw_step_s step_o
);
  import msw_pkg::*;

  msw_rk_state_e state_q;
  msw_rk_state_e state_d;
  logic dir_q;
  logic dir_d;
  logic [12:0] cnt_q;
  logic [12:0] cnt_d;
  msw_step_s step_q;
  msw_step_s step_d;
  msw_step_s vol_act;
  msw_step_s mem_act;
  logic btn;
  logic long_hit;

  assign btn = dir_q ? up_i : dn_i;
  assign vol_act = {dir_q, !dir_q, 2'b00};
  assign mem_act = {2'b00, dir_q, !dir_q};
  // [R14] long once held for the threshold
  assign long_hit = (cfg_i.mode == MSW_RK_MIXED) && (cnt_q >= cfg_i.thr_ms);

  // closure tracking and step decision
  always_comb begin
    state_d = state_q;
    dir_d = dir_q;
    cnt_d = cnt_q;
    step_d = '0;
    case (state_q)
      MSW_RK_IDLE: begin
        if (ready_i && cfg_i.mode != MSW_RK_OFF && (up_i || dn_i)) begin
          state_d = MSW_RK_HELD;
          dir_d = up_i;
          cnt_d = 13'h0;
        end
      end
      MSW_RK_HELD: begin
        if (tick_i && cnt_q != 13'h1fff) begin
          cnt_d = cnt_q + 13'h1;
        end
        if (!btn) begin
          state_d = MSW_RK_IDLE;
          // [R17] act on release
          case (cfg_i.mode)
            MSW_RK_VOLUME: step_d = vol_act;
            MSW_RK_MEMORY: step_d = mem_act;
            // [R15] short action chosen by setting
            MSW_RK_MIXED: step_d = cfg_i.short_is_vol ? vol_act : mem_act;
            default: step_d = '0;
          endcase
        end else if (long_hit) begin
          // [R16] long action fires while held
          state_d = MSW_RK_DONE;
          step_d = cfg_i.short_is_vol ? mem_act : vol_act;
        end
      end
      MSW_RK_DONE: begin
        if (!btn) begin
          state_d = MSW_RK_IDLE;
        end
      end
      default: state_d = MSW_RK_IDLE;
    endcase
  end

  // rocker registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= MSW_RK_IDLE;
      dir_q <= 1'b0;
      cnt_q <= 13'h0;
      step_q <= '0;
    end else begin
      state_q <= state_d;
      dir_q <= dir_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
    end
  end
  assign step_o = step_q;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_release_only_step: assert property ( // [R17]
    (state_q == MSW_RK_HELD && cfg_i.mode != MSW_RK_MIXED && btn) |=> step_o == '0)
    else $error("rocker step fired before release");
  chk_long_mem_held: assert property ( // [R16]
    (state_q == MSW_RK_HELD && btn && long_hit && cfg_i.short_is_vol)
      |=> (step_o.mem_up || step_o.mem_dn) && state_q == MSW_RK_DONE)
    else $error("long closure did not step memory while held");
  chk_volume_direction: assert property ( // [R20]
    (state_q == MSW_RK_HELD && !btn && cfg_i.mode == MSW_RK_VOLUME)
      |=> step_o.vol_up == $past(dir_q) && step_o.vol_dn == !$past(dir_q))
    else $error("volume step in the wrong direction");
endmodule // msw_rocker

// ---- verilog/msw_top.sv ----
// msw_top: memory select and rocker switch logic with an avalon slave
// assumes switch inputs asynchronous to sys_clk_i, avalon master on that clock
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`include "msw_map.svh"

// Overview of operation
// [R01] pull-down override high forces memory D
// [R02] otherwise start A, cycle, never D
// [R03] release restores memory active before override
// [R04] pull-up inverts override sense
// [R05] cycle sequences depend on valid memory count
// [R06] static override mode uses three memories
// [R07] pull-down static: 00 A, 10 B, x1 D
// [R08] pull-up static: 01 A, 11 B, x0 D
// [R09] plain static: 00 A, 10 B, 01 C, 11 D
// [R10] start at decoded memory, invalid gives A
// [R11] static modes follow switches continuously
// [R12] rocker modes: volume, memory or mixed
// [R13] rocker up/down step memory number
// [R14] mixed mode long threshold 1 to 5 s
// [R15] setting picks what short closures do
// [R16] long memory step fires while still held
// [R17] plain rocker modes act on release
// [R18] last valid memory wraps to A
// [R19] every change requests fade and indicator
// [R20] up raises gain, down lowers gain
// [R21] leave D only after full debounce
// [R22] inputs synchronized and debounced first
// [R23] rocker steps skip invalid, stop at ends
module msw_top #(
  parameter int TICK_CYCLES = `MSW_MS_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // switch pins
  input wire logic select_input_one_i,
  input wire logic select_input_two_i,
  input wire logic volume_up_input_i,
  input wire logic volume_down_input_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // audio path requests
  output msw_pkg::msw_mem_t memory_choice_o,
  output logic fade_req_o,
  output logic indicator_req_o,
  output logic gain_up_o,
  output logic gain_down_o
);
  import msw_pkg::*;

  // reset release synchroniser
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // millisecond tick
  logic [15:0] tick_cnt_q;
  logic [15:0] tick_cnt_d;
  logic tick;
  assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
  always_comb begin
    tick_cnt_d = tick ? 16'h0 : tick_cnt_q + 16'h1;
  end
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 16'h0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // register bus: one wait cycle, answer on the second
  logic ack_q;
  logic ack_d;
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic [15:0] deb_q;
  logic [15:0] deb_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] status;
  logic req;

  assign req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack_q;
  assign avs_readdata_o = rdata_q;

  // bus next values
  always_comb begin
    ack_d = req && !ack_q;
    cfg_d = cfg_q;
    deb_d = deb_q;
    rdata_d = rdata_q;
    if (avs_write_i && ack_q) begin
      case (avs_address_i)
        `MSW_REG_CONFIG: cfg_d = avs_writedata_i;
        `MSW_REG_DEBOUNCE: deb_d = avs_writedata_i[15:0];
        default: cfg_d = cfg_q;
      endcase
    end
    if (avs_read_i && !ack_q) begin
      case (avs_address_i)
        `MSW_REG_CONFIG: rdata_d = cfg_q;
        `MSW_REG_DEBOUNCE: rdata_d = {16'h0, deb_q};
        `MSW_REG_STATUS: rdata_d = status;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      cfg_q <= `MSW_CONFIG_RST;
      deb_q <= `MSW_DEBOUNCE_RST;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= ack_d;
      cfg_q <= cfg_d;
      deb_q <= deb_d;
      rdata_q <= rdata_d;
    end
  end

  // config fields
  msw_ms_mode_e mode;
  logic pull_up;
  logic [3:0] valid;
  logic ind_en;
  logic [2:0] thr_raw;
  logic [2:0] thr_s;
  msw_rk_cfg_s rk_cfg;
  assign mode = msw_ms_mode_e'(cfg_q[`MSW_CFG_MODE_HI:`MSW_CFG_MODE_LO]);
  assign pull_up = cfg_q[`MSW_CFG_PULL_UP];
  assign valid = cfg_q[`MSW_CFG_VALID_HI:`MSW_CFG_VALID_LO];
  assign ind_en = cfg_q[`MSW_CFG_IND_EN];
  assign thr_raw = cfg_q[`MSW_CFG_THR_HI:`MSW_CFG_THR_LO];
  // [R14] clamp threshold to 1..5 s, held in ms
  assign thr_s = (thr_raw < `MSW_THR_MIN_S) ? `MSW_THR_MIN_S :
                 (thr_raw > `MSW_THR_MAX_S) ? `MSW_THR_MAX_S : thr_raw;
  // [R12] one rocker mode at a time
  assign rk_cfg.mode = msw_rk_mode_e'(cfg_q[`MSW_CFG_ROCK_HI:`MSW_CFG_ROCK_LO]);
  assign rk_cfg.short_is_vol = cfg_q[`MSW_CFG_SHORT_VOL];
  assign rk_cfg.thr_ms = 13'({10'h0, thr_s} * `MSW_MS_PER_S);

  // [R22] debounce ahead of all decoding
  msw_sw_s sw;
  logic ready;
  msw_debounce u_debounce (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .sw_raw_i({volume_down_input_i, volume_up_input_i,
               select_input_two_i, select_input_one_i}),
    .tick_i(tick),
    .period_i(deb_q),
    .sw_o(sw),
    .ready_o(ready)
  );

  // rocker on the volume inputs
  msw_step_s step;
  msw_rocker u_rocker (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .up_i(sw.volume_up_input),
    .dn_i(sw.volume_down_input),
    .tick_i(tick),
    .ready_i(ready),
    .cfg_i(rk_cfg),
    .step_o(step)
  );

  // next valid memory above, wrapping to A
  function automatic msw_mem_t next_wrap(msw_mem_t cur, logic [3:0] ok);
    msw_mem_t nxt;
    nxt = `MSW_MEM_A;
    for (int i = 3; i >= 1; i--) begin
      if (2'(i) > cur && ok[i]) begin
        nxt = 2'(i);
      end
    end
    return nxt;
  endfunction

  // next valid memory in a direction, else unchanged
  function automatic msw_mem_t step_dir(msw_mem_t cur, logic [3:0] ok, logic up);
    msw_mem_t nxt;
    nxt = cur;
    for (int i = 3; i >= 0; i--) begin
      if (up && 2'(i) > cur && ok[i]) begin
        nxt = 2'(i);
      end
    end
    for (int i = 0; i <= 3; i++) begin
      if (!up && 2'(i) < cur && ok[i]) begin
        nxt = 2'(i);
      end
    end
    return nxt;
  endfunction

  // [R04] polarity sets the active override level
  logic s1_act;
  logic s2_act;
  logic s1_press;
  logic s1_prev_q;
  assign s1_act = pull_up ? !sw.select_input_one : sw.select_input_one;
  assign s2_act = pull_up ? !sw.select_input_two : sw.select_input_two;
  assign s1_press = ready && s1_act && !s1_prev_q;

  // memory selection state
  msw_sel_state_e sel_q;
  msw_sel_state_e sel_d;
  msw_mem_t mem_q;
  msw_mem_t mem_d;
  msw_mem_t saved_q;
  msw_mem_t saved_d;
  msw_mem_t stat_idx;
  logic [3:0] cyc_ok;
  logic rk_move;

  assign rk_move = step.mem_up || step.mem_dn;
  // [R05] three-memory limit drops D from cycling
  assign cyc_ok = (mode == MSW_MOM_DONLY) ? (valid & 4'h7) : valid;

  // [R07] [R08] [R09] static decode
  always_comb begin
    if (mode == MSW_STAT_PLAIN) begin
      stat_idx = {sw.select_input_two, sw.select_input_one};
    end else if (s2_act) begin
      stat_idx = `MSW_MEM_D;
    end else begin
      stat_idx = sw.select_input_one ? `MSW_MEM_B : `MSW_MEM_A;
    end
  end

  // memory next-state logic
  always_comb begin
    sel_d = MSW_SEL_NORMAL;
    mem_d = mem_q;
    saved_d = saved_q;
    if (ready) begin
      case (mode)
        MSW_MOMENTARY: begin
          // [R18] wrap after the last valid memory
          if (s1_press) begin
            mem_d = next_wrap(mem_q, cyc_ok);
          end else if (rk_move) begin
            // [R13] [R23] rocker step over valid memories
            mem_d = step_dir(mem_q, cyc_ok, step.mem_up);
          end
        end
        MSW_MOM_DONLY: begin
          case (sel_q)
            MSW_SEL_NORMAL: begin
              if (s2_act) begin
                // [R01] override forces D, first input ignored
                sel_d = MSW_SEL_OVERRIDE;
                saved_d = mem_q;
                mem_d = `MSW_MEM_D;
              end else if (s1_press) begin
                // [R02] cycle without D
                mem_d = next_wrap(mem_q, cyc_ok);
              end else if (rk_move) begin
                mem_d = step_dir(mem_q, cyc_ok, step.mem_up);
              end
            end
            MSW_SEL_OVERRIDE: begin
              // [R21] s2 level is debounced before leaving D
              if (s2_act) begin
                sel_d = MSW_SEL_OVERRIDE;
                mem_d = `MSW_MEM_D;
              end else begin
                // [R03] reload the memory from before the jump
                mem_d = saved_q;
              end
            end
            default: sel_d = MSW_SEL_NORMAL;
          endcase
        end
        default: begin
          // [R06] [R10] [R11] follow switches, invalid gives A
          sel_d = (mode == MSW_STAT_DONLY && s2_act) ? MSW_SEL_OVERRIDE :
                  MSW_SEL_NORMAL;
          mem_d = valid[stat_idx] ? stat_idx : `MSW_MEM_A;
        end
      endcase
    end
  end

  // selection registers and audio requests
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= MSW_SEL_NORMAL;
      mem_q <= `MSW_MEM_A;
      saved_q <= `MSW_MEM_A;
      s1_prev_q <= 1'b0;
      fade_req_o <= 1'b0;
      indicator_req_o <= 1'b0;
      gain_up_o <= 1'b0;
      gain_down_o <= 1'b0;
    end else begin
      sel_q <= sel_d;
      mem_q <= mem_d;
      saved_q <= saved_d;
      s1_prev_q <= ready && s1_act;
      // [R19] fade and indicator on every change
      fade_req_o <= (mem_d != mem_q);
      indicator_req_o <= (mem_d != mem_q) && ind_en;
      // [R20] volume steps to the gain stage
      gain_up_o <= step.vol_up;
      gain_down_o <= step.vol_dn;
    end
  end

  assign memory_choice_o = mem_q;
  assign status = {23'h0, ready, sw, 1'b0, sel_q == MSW_SEL_OVERRIDE, mem_q};

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_override_on;
    ready && mode == MSW_MOM_DONLY && s2_act && $stable(cfg_q);
  endsequence
  sequence s_override_off;
    sel_q == MSW_SEL_OVERRIDE && ready && mode == MSW_MOM_DONLY && !s2_act;
  endsequence

  chk_override_forces_d: assert property ( // [R01]
    s_override_on |=> mem_q == `MSW_MEM_D && sel_q == MSW_SEL_OVERRIDE)
    else $error("override did not force memory D");
  chk_cycle_skips_d: assert property ( // [R02]
    (mode == MSW_MOM_DONLY && sel_q == MSW_SEL_NORMAL && s1_press && !s2_act)
      |=> mem_q != `MSW_MEM_D)
    else $error("cycling reached memory D");
  chk_restore_prior: assert property ( // [R03]
    s_override_off |=> mem_q == $past(saved_q) && sel_q == MSW_SEL_NORMAL)
    else $error("prior memory not restored");
  chk_static_d_decode: assert property ( // [R07]
    (ready && mode == MSW_STAT_DONLY && !pull_up && sw.select_input_two
      && valid[3]) |=> mem_q == `MSW_MEM_D)
    else $error("static override did not select D");
  chk_invalid_gives_a: assert property ( // [R10]
    (ready && mode == MSW_STAT_PLAIN && !valid[stat_idx]) |=> mem_q == `MSW_MEM_A)
    else $error("invalid static memory not replaced by A");
  chk_wrap_to_a: assert property ( // [R18]
    ((mode == MSW_MOMENTARY || (mode == MSW_MOM_DONLY && sel_q == MSW_SEL_NORMAL && !s2_act))
      && s1_press && (cyc_ok & 4'(4'he << mem_q)) == 4'h0) |=> mem_q == `MSW_MEM_A)
    else $error("last memory did not wrap to A");
  chk_fade_on_change: assert property ( // [R19]
    (mem_q != $past(mem_q)) |-> fade_req_o)
    else $error("memory change without fade request");
endmodule // msw_top
